// ==== pkg/spl_map.vh ====
// spl_map.vh: offsets, field positions, reset values and timing counts
// of the sector protection lock block, as `define macros.
// assumes: included by bare name from design files, guarded once.
`ifndef SPL_MAP_VH
`define SPL_MAP_VH

// register map on the plain port
`define SPL_A_CMD 4'h0
`define SPL_A_STATUS 4'h1
`define SPL_A_MODE 4'h2
`define SPL_A_SECT 4'h3
`define SPL_A_PPB 4'h4
`define SPL_A_DYB 4'h5
`define SPL_A_PW0 4'h6
`define SPL_A_PW1 4'h7
`define SPL_A_PWD0 4'h8
`define SPL_A_PWD1 4'h9

// command codes written to the command register
`define SPL_C_LOCK_CLR 8'h01
`define SPL_C_UNLOCK 8'h02
`define SPL_C_PPB_PROG 8'h03
`define SPL_C_PPB_ERASE 8'h04
`define SPL_C_DYB_WR 8'h05
`define SPL_C_PW_PROG 8'h06
`define SPL_C_MODE_PROG 8'h07
`define SPL_C_SOFT_RST 8'h08
`define SPL_C_ERR_CLR 8'h09

// status fields
`define SPL_S_BUSY 0
`define SPL_S_PERR 1
`define SPL_S_LOCK 2
`define SPL_S_MODE_LO 3
`define SPL_S_MODE_HI 4

// mode bits
`define SPL_MODE_DEFAULT 2'h3
`define SPL_MODE_PERSIST 2'h2
`define SPL_MODE_PASSWORD 2'h1

// reset values
`define SPL_PW_RESET 64'hFFFFFFFFFFFFFFFF
`define SPL_UNDEF_DATA 32'h00000000

// timing: retry interval in ns, clock period in ns
`define SPL_RETRY_NS 100000
`define SPL_CLK_NS 100
`define SPL_RETRY_CYC (`SPL_RETRY_NS / `SPL_CLK_NS)

`endif

// ==== rtl/spl_lock.v ====
// spl_lock.v: sector protection lock, persistent and dynamic sector bits,
// password unlock with retry interval.
// assumes: one clock clk_sys, registers reached over a plain strobe port;
// mode and persistent bits are non-volatile, kept across reset here.
`include "spl_map.vh"
`default_nettype none

module spl_lock #(
  parameter SECTORS = 256,
  parameter SECT_W = 8,
  parameter RETRY_CYC = `SPL_RETRY_CYC
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg persistent_lock_bit,
  output reg busy_flag,
  output reg prog_err,
  output reg sect_unprot
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_r;
  reg [1:0] protection_mode_register;
  reg [SECTORS-1:0] persistent_sector_bit;
  reg [SECTORS-1:0] dynamic_sector_bit;
  reg [63:0] pw_store_r;
  reg [63:0] pw_try_r;
  reg [SECT_W-1:0] sect_r;
  reg [16:0] retry_cnt_r;
  reg nv_init_r;
  // power-up marker: no reset, so non-volatile state survives arst_n
  reg nv_loaded_r;

  wire pw_mode = protection_mode_register == `SPL_MODE_PASSWORD;
  wire cmd_wr = reg_wr && reg_addr == `SPL_A_CMD;
  wire [7:0] cmd = reg_wdata[7:0];

  function sel_bit;
    input [SECTORS-1:0] vec;
    input [SECT_W-1:0] idx;
    begin
      sel_bit = vec[idx];
    end
  endfunction

  // ****************************************************************
  // non-volatile storage: kept across reset, reloaded on every edge until nv_loaded_r is 1
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!nv_loaded_r) begin
      // unknown at power-up does not land here, only a known 0 does
      nv_loaded_r <= 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (nv_loaded_r !== 1'b1) begin
      protection_mode_register <= `SPL_MODE_DEFAULT;
      persistent_sector_bit <= {SECTORS{1'b1}};
      pw_store_r <= `SPL_PW_RESET;
    end else if (nv_init_r && cmd_wr && state_r == ST_IDLE) begin
      case (cmd)
        `SPL_C_PPB_PROG: begin
          if (persistent_lock_bit)
            persistent_sector_bit[sect_r] <= 1'b0;
        end
        `SPL_C_PPB_ERASE: begin
          if (persistent_lock_bit)
            persistent_sector_bit <= {SECTORS{1'b1}};
        end
        `SPL_C_PW_PROG: begin
          if (protection_mode_register == `SPL_MODE_DEFAULT)
            pw_store_r <= pw_store_r & pw_try_r;
        end
        `SPL_C_MODE_PROG: begin
          // one-shot, only clears bits, never erased
          if (protection_mode_register == `SPL_MODE_DEFAULT &&
              (reg_wdata[9:8] == `SPL_MODE_PERSIST ||
               reg_wdata[9:8] == `SPL_MODE_PASSWORD))
            protection_mode_register <= reg_wdata[9:8];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      nv_init_r <= 1'b0;
    else
      nv_init_r <= 1'b1;
  end

  // ****************************************************************
  // volatile control: lock bit, dynamic bits, unlock sequencer
  // ****************************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // lock resolved from mode after first edge below
      persistent_lock_bit <= 1'b0;
      dynamic_sector_bit <= {SECTORS{1'b1}};
      state_r <= ST_IDLE;
      busy_flag <= 1'b0;
      prog_err <= 1'b0;
      retry_cnt_r <= 17'h00000;
      sect_r <= {SECT_W{1'b0}};
      pw_try_r <= 64'h0000000000000000;
    end else if (!nv_init_r) begin
      // one lock bit, resolved from the retained mode
      persistent_lock_bit <= !pw_mode;
    end else begin
      if (reg_wr && reg_addr == `SPL_A_SECT)
        sect_r <= reg_wdata[SECT_W-1:0];
      if (reg_wr && reg_addr == `SPL_A_PW0)
        pw_try_r[31:0] <= reg_wdata;
      if (reg_wr && reg_addr == `SPL_A_PW1)
        pw_try_r[63:32] <= reg_wdata;
      case (state_r)
        ST_IDLE: begin
          if (cmd_wr) begin
            case (cmd)
              `SPL_C_LOCK_CLR: persistent_lock_bit <= 1'b0;
              `SPL_C_DYB_WR: dynamic_sector_bit[sect_r] <= reg_wdata[8];
              `SPL_C_ERR_CLR: prog_err <= 1'b0;
              `SPL_C_PPB_PROG, `SPL_C_PPB_ERASE: begin
                if (!persistent_lock_bit)
                  prog_err <= 1'b1;
              end
              `SPL_C_UNLOCK: begin
                if (pw_mode) begin
                  if (pw_try_r == pw_store_r) begin
                    persistent_lock_bit <= 1'b1;
                  end else begin
                    prog_err <= 1'b1;
                    busy_flag <= 1'b1;
                    retry_cnt_r <= RETRY_CYC[16:0];
                    state_r <= ST_WAIT;
                  end
                end
              end
              // soft reset leaves the lock bit alone
              `SPL_C_SOFT_RST: prog_err <= 1'b0;
              default: begin
              end
            endcase
          end
        end
        ST_WAIT: begin
          // commands refused while busy
          if (retry_cnt_r == 17'h00001) begin
            busy_flag <= 1'b0;
            state_r <= ST_IDLE;
          end
          retry_cnt_r <= retry_cnt_r - 17'h00001;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // read port and sector verdict
  // ****************************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
      sect_unprot <= 1'b0;
    end else begin
      sect_unprot <= sel_bit(persistent_sector_bit, sect_r) &
                     sel_bit(dynamic_sector_bit, sect_r);
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `SPL_A_STATUS: reg_rdata <= {27'h0000000, protection_mode_register,
                                       persistent_lock_bit, prog_err,
                                       busy_flag};
          `SPL_A_MODE: reg_rdata <= {30'h00000000, protection_mode_register};
          `SPL_A_SECT: reg_rdata <= {{(32-SECT_W){1'b0}}, sect_r};
          `SPL_A_PPB: reg_rdata <= {31'h00000000,
                                    sel_bit(persistent_sector_bit, sect_r)};
          `SPL_A_DYB: reg_rdata <= {31'h00000000,
                                    sel_bit(dynamic_sector_bit, sect_r)};
          `SPL_A_PWD0: reg_rdata <= pw_mode ? `SPL_UNDEF_DATA :
                                    pw_store_r[31:0];
          `SPL_A_PWD1: reg_rdata <= pw_mode ? `SPL_UNDEF_DATA :
                                    pw_store_r[63:32];
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== verification/spl_host.sv ====
// spl_host.sv: host controller model driving the register port
// assumes: block samples one-cycle strobes on rising clk_sys
`default_nettype none
module spl_host (
  input wire logic clk_sys,
  output logic [3:0] reg_addr = 4'h0,
  output logic [31:0] reg_wdata = 32'h0,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***
  // register port cycles
  // ***
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== verification/spl_lock_chk.sv ====
// spl_lock_chk.sv: port assertions for spl_lock
// assumes: bound to spl_lock, one clock, async active-low reset
`include "spl_map.vh"
`default_nettype none
module spl_lock_chk #(parameter RETRY_CYC = 10) (
  input wire clk_sys,
  input wire arst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire persistent_lock_bit,
  input wire busy_flag,
  input wire prog_err,
  input wire sect_unprot
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [7:0] code = (reg_wr && reg_addr == `SPL_A_CMD) ?
    reg_wdata[7:0] : 8'h0;
  logic [15:0] busy_n_r;
  always @(posedge clk_sys or negedge arst_n)
    if (!arst_n) busy_n_r <= 16'h0;
    else busy_n_r <= busy_flag ? busy_n_r + 16'h1 : 16'h0;
  // ***
  // lock and retry properties
  // ***
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  clr_lock_a: assert property (
    code == `SPL_C_LOCK_CLR && !busy_flag |=> !persistent_lock_bit)
    else $error("lock clear not taken");
  lock_rise_a: assert property (
    $rose(persistent_lock_bit) && $past(arst_n, 3) |->
    $past(code) == `SPL_C_UNLOCK) else $error("lock set without unlock");
  unl_fast_a: assert property (
    $rose(persistent_lock_bit) |-> !busy_flag)
    else $error("busy after good unlock");
  bad_pw_a: assert property (
    $rose(busy_flag) |-> prog_err && !persistent_lock_bit)
    else $error("failed unlock flags wrong");
  busy_min_a: assert property (
    $fell(busy_flag) |-> busy_n_r >= RETRY_CYC * 4 / 5)
    else $error("retry interval too short");
  busy_max_a: assert property (
    busy_n_r <= RETRY_CYC * 6 / 5) else $error("retry interval too long");
  ppb_deny_a: assert property (
    code == `SPL_C_PPB_PROG && !persistent_lock_bit && !busy_flag
    |=> prog_err) else $error("locked program not flagged");
  soft_keep_a: assert property (
    code == `SPL_C_SOFT_RST |=> $stable(persistent_lock_bit))
    else $error("soft reset moved lock");
  busy_hold_a: assert property (
    busy_flag && reg_wr |=> $stable(persistent_lock_bit))
    else $error("command taken while busy");
endmodule
bind spl_lock spl_lock_chk #(.RETRY_CYC(RETRY_CYC)) u_chk (.clk_sys,
  .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .persistent_lock_bit, .busy_flag, .prog_err, .sect_unprot);
`default_nettype wire

// ==== verification/spl_lock_test.sv ====
// spl_lock_test.sv: self-checking bench for spl_lock
// assumes: host model drives the port, checker is bound to the dut
`include "spl_map.vh"
`default_nettype none
module spl_lock_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, lock, busy, perr, unprot;
  int errors = 0;
  int checks_done = 0;
  always #50 clk_sys = ~clk_sys;
  spl_lock #(.RETRY_CYC(10)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .persistent_lock_bit(lock),
    .busy_flag(busy), .prog_err(perr), .sect_unprot(unprot));
  spl_host u_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  // ***
  // helpers
  // ***
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [1:0] m = 2'h0);
    u_host.wr(`SPL_A_CMD, {22'h0, m, c});
    #1;
  endtask
  task automatic pw(input logic [31:0] lo, input logic [31:0] hi);
    u_host.wr(`SPL_A_PW0, lo);
    u_host.wr(`SPL_A_PW1, hi);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rst;
    @(posedge clk_sys);
    arst_n <= 1'b0;
    tick(2);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(2);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ***
  // tests, about 140 cycles; watchdog allows 2000
  // ***
  initial begin
    #200000;
    errors++;
    close_out;
  end
  initial begin
    rst;
    chkb(lock, 1'b1);
    rc(`SPL_A_PWD0, 32'hFFFFFFFF);
    rc(`SPL_A_PWD1, 32'hFFFFFFFF);
    rc(`SPL_A_MODE, 32'h3);
    u_host.wr(`SPL_A_SECT, 32'h5);
    cmd(`SPL_C_DYB_WR, 2'h0);
    tick(1);
    chkb(unprot, 1'b0);
    cmd(`SPL_C_DYB_WR, 2'h1);
    tick(1);
    chkb(unprot, 1'b1);
    cmd(`SPL_C_PPB_PROG);
    rc(`SPL_A_PPB, 32'h0);
    chkb(unprot, 1'b0);
    cmd(`SPL_C_PPB_ERASE);
    rc(`SPL_A_PPB, 32'h1);
    cmd(`SPL_C_LOCK_CLR);
    chkb(lock, 1'b0);
    cmd(`SPL_C_PPB_PROG);
    chkb(perr, 1'b1);
    rc(`SPL_A_PPB, 32'h1);
    cmd(`SPL_C_SOFT_RST);
    chkb(lock, 1'b0);
    cmd(`SPL_C_DYB_WR, 2'h0);
    tick(1);
    chkb(unprot, 1'b0);
    cmd(`SPL_C_ERR_CLR);
    pw(32'hFFFFFFFF, 32'hFFFFFFFF);
    cmd(`SPL_C_UNLOCK);
    chkb(lock, 1'b0);
    tick(14);
    rst;
    chkb(lock, 1'b1);
    u_host.wr(`SPL_A_SECT, 32'h5);
    tick(1);
    chkb(unprot, 1'b1);
    pw(32'h12345678, 32'hFFFF0000);
    cmd(`SPL_C_PW_PROG);
    pw(32'hFFFFFFFF, 32'h0F0FFFFF);
    cmd(`SPL_C_PW_PROG);
    rc(`SPL_A_PWD0, 32'h12345678);
    rc(`SPL_A_PWD1, 32'h0F0F0000);
    cmd(`SPL_C_MODE_PROG, 2'h1);
    cmd(`SPL_C_MODE_PROG, 2'h3);
    rc(`SPL_A_MODE, 32'h1);
    pw(32'h0, 32'h0);
    cmd(`SPL_C_PW_PROG);
    rc(`SPL_A_PWD0, `SPL_UNDEF_DATA);
    cmd(`SPL_C_LOCK_CLR);
    chkb(lock, 1'b0);
    rst;
    chkb(lock, 1'b0);
    rc(`SPL_A_MODE, 32'h1);
    pw(32'h12345678, 32'h0F0F0001);
    cmd(`SPL_C_UNLOCK);
    chkb(perr, 1'b1);
    chkb(lock, 1'b0);
    cmd(`SPL_C_ERR_CLR);
    chkb(perr, 1'b1);
    tick(5);
    chkb(busy, 1'b1);
    tick(6);
    chkb(busy, 1'b0);
    cmd(`SPL_C_ERR_CLR);
    pw(32'h12345678, 32'h0F0F0000);
    cmd(`SPL_C_UNLOCK);
    chkb(lock, 1'b1);
    chkb(busy, 1'b0);
    cmd(`SPL_C_PPB_PROG);
    rc(`SPL_A_PPB, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
